// ### verilog/cdc_pkg.sv
`default_nettype none
package cdc_pkg;
  // ---------------------------------------------------------------------------
  // Register map (byte-wide index, 16-bit data)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_RESULT [2] = '{8'h01, 8'h02};
  localparam logic [7:0] ADDR_SETUP  [2] = '{8'h0b, 8'h0e};
  localparam logic [7:0] ADDR_CONFIG    = 8'h0f;
  localparam logic [7:0] ADDR_TRIM_POS  = 8'h11;
  localparam logic [7:0] ADDR_TRIM_NEG  = 8'h12;
  localparam logic [7:0] ADDR_OFFSET [2] = '{8'h13, 8'h15};
  localparam logic [7:0] ADDR_GAIN   [2] = '{8'h14, 8'h16};
  localparam logic [7:0] ADDR_CONFIG2   = 8'h1a;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int SETUP_RANGE_LO = 6;   // Bits 7:6 range select
  localparam int SETUP_DIFF_BIT = 5;   // differential_select
  localparam int CFG_CH1_EN_BIT = 4;
  localparam int CFG_CH2_EN_BIT = 3;
  localparam int TRIM_CONN_BIT  = 7;   // Bit 7 trim connect; bits 4:0 trim code
  localparam int CFG2_RATE_LO   = 4;   // Bits 5:4 filter rate
  localparam int ST_RDY1_BIT    = 0;
  localparam int ST_RDY2_BIT    = 1;
  localparam int ST_BUSY_BIT    = 2;
  localparam int ST_PDOWN_BIT   = 3;
  localparam int TRIM_SHIFT     = 6;   // Trim LSB weight as a left shift: 64 raw code units

  // ---------------------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  BYTE_RESET      = 8'h00;
  localparam logic [15:0] OFFSET_RESET    = 16'h8000;
  localparam logic [15:0] DIFF_ZERO_CODE  = 16'h8000;
  localparam logic [15:0] SE_ZERO_OFFSET  = 16'h3000;
  localparam logic [15:0] GAIN_RESET      = 16'h8000;
  localparam logic [15:0] GAIN_CAL_TARGET = 16'hf000;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ       = 250;
  localparam int CONV_US_0     = 5000;
  localparam int CONV_US_1     = 20000;
  localparam int CONV_US_2     = 50000;
  localparam int CONV_US_3     = 60000;
  localparam int CONV_CYC_0    = CONV_US_0 * CLK_MHZ;
  localparam int CONV_CYC_1    = CONV_US_1 * CLK_MHZ;
  localparam int CONV_CYC_2    = CONV_US_2 * CLK_MHZ;
  localparam int CONV_CYC_3    = CONV_US_3 * CLK_MHZ;
  localparam logic [1:0] LOAD_WAIT_CYC = 2'd3;  // Lets the OTP word pass its synchroniser
  localparam logic [4:0] DIV_LAST_STEP = 5'd31;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_IDLE  = 3'b000,
    MODE_CONT  = 3'b001,
    MODE_SINGLE = 3'b010,
    MODE_PDOWN = 3'b011,
    MODE_OFSCAL = 3'b101,
    MODE_GAINCAL = 3'b110
  } cdc_mode_t;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_IDLE = 2'b01,
    ST_CONV = 2'b11,
    ST_DIV  = 2'b10
  } cdc_state_t;
endpackage
`default_nettype wire

// ### verilog/cdc_trim_ctrl.sv
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
module cdc_trim_ctrl #(
  parameter int CONV_CYC_T0 = cdc_pkg::CONV_CYC_0,
  parameter int CONV_CYC_T1 = cdc_pkg::CONV_CYC_1,
  parameter int CONV_CYC_T2 = cdc_pkg::CONV_CYC_2,
  parameter int CONV_CYC_T3 = cdc_pkg::CONV_CYC_3
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Factory coefficient store
  input  wire logic [15:0] otp_gain,
  // Converter front end
  input  wire logic [15:0] afe_pos_code,
  input  wire logic [15:0] afe_neg_code,
  output logic             excitation_enable,
  output logic             afe_channel,
  output logic      [1:0]  afe_range,
  output logic             afe_power_down,
  output logic             cap_neg_input_connect,
  output logic             pos_trim_connect,
  output logic      [4:0]  pos_trim_code,
  output logic             neg_trim_connect,
  output logic      [4:0]  neg_trim_code,
  output logic             filter_rate_sel_hi,
  output logic             filter_rate_sel_lo
);
  import cdc_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [15:0]        pos_meta, pos_sync, neg_meta, neg_sync, otp_meta, otp_sync;
  cdc_state_t         state;
  cdc_mode_t          op_mode;
  logic [1:0]         ch_en;
  logic               cur_ch;
  logic [31:0]        timer;
  logic [31:0]        conv_limit;
  logic [1:0]         load_cnt;
  logic [7:0]         setup  [2];
  logic [15:0]        offset [2];
  logic [15:0]        gain   [2];
  logic [15:0]        result [2];
  logic [1:0]         ready;
  logic               conv_done, mode_wr, mode_ok, cur_diff, div_done;
  logic               done_single, done_ofs, done_gain;
  logic signed [17:0] pos_in, neg_in, trim_p, trim_n, raw_delta;
  logic signed [35:0] product;
  logic signed [20:0] scaled, corrected, ofs_calc;
  logic [15:0]        conv_code, ofs_code, div_den;
  logic [16:0]        div_rem, rem_sh;
  logic [31:0]        div_quo;
  logic [4:0]         div_cnt;
  logic               rem_ge;

  // Clamp a signed value into the 16-bit code space
  function automatic logic [15:0] clamp16(input logic signed [20:0] v);
    if (v < 0) begin
      return 16'h0000;
    end else if (v > 21'sh00ffff) begin
      return 16'hffff;
    end
    return v[15:0];
  endfunction

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  // Front end and OTP words come from another domain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_meta <= '0;
      pos_sync <= '0;
      neg_meta <= '0;
      neg_sync <= '0;
      otp_meta <= '0;
      otp_sync <= '0;
    end else begin
      pos_meta <= afe_pos_code;
      pos_sync <= pos_meta;
      neg_meta <= afe_neg_code;
      neg_sync <= neg_meta;
      otp_meta <= otp_gain;
      otp_sync <= otp_meta;
    end
  end

  // ---------------------------------------------------------------------------
  // Conversion arithmetic
  // ---------------------------------------------------------------------------
  // Trim comes off before gain so it shifts the input window
  always_comb begin
    cur_diff  = setup[cur_ch][SETUP_DIFF_BIT];
    pos_in    = $signed({2'b00, pos_sync});
    neg_in    = $signed({2'b00, neg_sync});
    trim_p    = pos_trim_connect ? 18'(pos_trim_code) << TRIM_SHIFT : 18'sd0;
    trim_n    = neg_trim_connect ? 18'(neg_trim_code) << TRIM_SHIFT : 18'sd0;
    if (cur_diff) begin
      raw_delta = (pos_in - trim_p) - (neg_in - trim_n);
    end else begin
      raw_delta = pos_in - (trim_p + trim_n);
    end
    product   = raw_delta * $signed({2'b00, gain[cur_ch]});
    scaled    = product[35:15];
    // Single-ended zero sits at code 0 once the 0x3000 offset is removed
    corrected = scaled + $signed({5'b0, offset[cur_ch]})
              - (cur_diff ? 21'sd0 : $signed({5'b0, SE_ZERO_OFFSET}));
    conv_code = clamp16(corrected);
    ofs_calc  = $signed({5'b0, (cur_diff ? DIFF_ZERO_CODE : SE_ZERO_OFFSET)}) - scaled;
    ofs_code  = clamp16(ofs_calc);
  end

  // ---------------------------------------------------------------------------
  // Control decode
  // ---------------------------------------------------------------------------
  always_comb begin
    unique case ({filter_rate_sel_hi, filter_rate_sel_lo})
      2'b00: conv_limit = 32'(CONV_CYC_T0);
      2'b01: conv_limit = 32'(CONV_CYC_T1);
      2'b10: conv_limit = 32'(CONV_CYC_T2);
      2'b11: conv_limit = 32'(CONV_CYC_T3);
    endcase
    mode_wr     = reg_wr && (reg_addr == ADDR_CONFIG);
    mode_ok     = (reg_wdata[2:0] != 3'b100) && (reg_wdata[2:0] != 3'b111);
    conv_done   = (state == ST_CONV) && (timer == conv_limit - 32'd1) && !mode_wr;
    done_single = conv_done && (op_mode == MODE_SINGLE);
    done_ofs    = conv_done && (op_mode == MODE_OFSCAL);
    div_done    = (state == ST_DIV) && (div_cnt == DIV_LAST_STEP);
    done_gain   = div_done;
    rem_sh      = {div_rem[15:0], div_quo[31]};
    rem_ge      = rem_sh >= {1'b0, div_den};
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  // A mode write aborts any conversion so new settings start cleanly
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= ST_LOAD;
      cur_ch   <= 1'b0;
      timer    <= '0;
      load_cnt <= '0;
    end else begin
      unique case (state)
        ST_LOAD: begin
          load_cnt <= load_cnt + 2'd1;
          if (load_cnt == LOAD_WAIT_CYC) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          timer <= '0;
          if ((ch_en != 2'b00) && !mode_wr &&
              (op_mode inside {MODE_CONT, MODE_SINGLE, MODE_OFSCAL, MODE_GAINCAL})) begin
            state  <= ST_CONV;
            cur_ch <= !ch_en[0];
          end
        end
        ST_CONV: begin
          timer <= timer + 32'd1;
          if (mode_wr) begin
            state <= ST_IDLE;
          end else if (conv_done) begin
            timer <= '0;
            if (op_mode == MODE_GAINCAL) begin
              state <= ST_DIV;
            end else if (op_mode == MODE_CONT) begin
              cur_ch <= ch_en[!cur_ch] ? !cur_ch : cur_ch;   // Alternate enabled channels
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_DIV: begin
          if (div_done) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Gain calibration divider: scaled target over measured delta
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_rem <= '0;
      div_quo <= '0;
      div_den <= '0;
      div_cnt <= '0;
    end else if (conv_done && (op_mode == MODE_GAINCAL)) begin
      div_rem <= '0;
      div_quo <= {1'b0, GAIN_CAL_TARGET, 15'b0};
      div_den <= clamp16(21'(raw_delta));  // Zero or negative saturates the gain
      div_cnt <= '0;
    end else if (state == ST_DIV) begin
      div_rem <= rem_ge ? rem_sh - {1'b0, div_den} : rem_sh;
      div_quo <= {div_quo[30:0], rem_ge};
      div_cnt <= div_cnt + 5'd1;
    end
  end

  // ---------------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------------
  // Mode field; single and calibration runs fall back to idle when done
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_mode <= MODE_IDLE;
      ch_en   <= '0;
    end else if (mode_wr) begin
      if (mode_ok) begin
        op_mode <= cdc_mode_t'(reg_wdata[2:0]);
      end
      ch_en <= {reg_wdata[CFG_CH2_EN_BIT], reg_wdata[CFG_CH1_EN_BIT]};
    end else if (done_single || done_ofs || done_gain) begin
      op_mode <= MODE_IDLE;
    end
  end

  // Shared trim and filter settings; reserved bits are not stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_trim_connect   <= 1'b0;
      pos_trim_code      <= '0;
      neg_trim_connect   <= 1'b0;
      neg_trim_code      <= '0;
      filter_rate_sel_hi <= 1'b0;
      filter_rate_sel_lo <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_TRIM_POS) begin
        pos_trim_connect <= reg_wdata[TRIM_CONN_BIT];
        pos_trim_code    <= reg_wdata[4:0];
      end
      if (reg_addr == ADDR_TRIM_NEG) begin
        neg_trim_connect <= reg_wdata[TRIM_CONN_BIT];
        neg_trim_code    <= reg_wdata[4:0];
      end
      if (reg_addr == ADDR_CONFIG2) begin
        filter_rate_sel_hi <= reg_wdata[CFG2_RATE_LO+1];
        filter_rate_sel_lo <= reg_wdata[CFG2_RATE_LO];
      end
    end
  end

  // Per-channel setup, coefficients, results and ready flags
  for (genvar c = 0; c < 2; c++) begin : g_ch
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        setup[c]  <= BYTE_RESET;
        offset[c] <= OFFSET_RESET;
        gain[c]   <= GAIN_RESET;
        result[c] <= '0;
        ready[c]  <= 1'b0;
      end else begin
        if (reg_wr && (reg_addr == ADDR_SETUP[c])) begin
          setup[c] <= {reg_wdata[7:6], reg_wdata[SETUP_DIFF_BIT], 5'b0};
        end
        // Host write beats a calibration finishing in the same cycle
        if (reg_wr && (reg_addr == ADDR_OFFSET[c])) begin
          offset[c] <= reg_wdata;
        end else if (done_ofs && (cur_ch == c[0])) begin
          offset[c] <= ofs_code;
        end
        if (state == ST_LOAD) begin
          gain[c] <= otp_sync;
        end else if (reg_wr && (reg_addr == ADDR_GAIN[c])) begin
          gain[c] <= reg_wdata;
        end else if (done_gain && (cur_ch == c[0])) begin
          gain[c] <= (div_quo[30:15] != 16'h0000) ? 16'hffff
                   : {div_quo[14:0], rem_ge};
        end
        if (conv_done && (cur_ch == c[0]) &&
            (op_mode == MODE_CONT || op_mode == MODE_SINGLE)) begin
          result[c] <= conv_code;
        end
        // A new result wins over a clearing read in the same cycle
        if (conv_done && (cur_ch == c[0]) &&
            (op_mode == MODE_CONT || op_mode == MODE_SINGLE)) begin
          ready[c] <= 1'b1;
        end else if (reg_rd && (reg_addr == ADDR_RESULT[c])) begin
          ready[c] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Front-end drive
  // ---------------------------------------------------------------------------
  // Registered one cycle late to keep the pins glitch free
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      excitation_enable     <= 1'b0;
      afe_channel           <= 1'b0;
      afe_range             <= '0;
      afe_power_down        <= 1'b0;
      cap_neg_input_connect <= 1'b0;
    end else begin
      excitation_enable     <= (state == ST_CONV);
      afe_channel           <= cur_ch;
      afe_range             <= setup[cur_ch][SETUP_RANGE_LO+1:SETUP_RANGE_LO];
      afe_power_down        <= (op_mode == MODE_PDOWN);
      cap_neg_input_connect <= (state == ST_CONV) && cur_diff;
    end
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  // Data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        ADDR_STATUS: reg_rdata <= {12'h000, (op_mode == MODE_PDOWN),
                                   (state != ST_IDLE), ready[1], ready[0]};
        ADDR_RESULT[0]: reg_rdata <= result[0];
        ADDR_RESULT[1]: reg_rdata <= result[1];
        ADDR_SETUP[0]:  reg_rdata <= {8'h00, setup[0]};
        ADDR_SETUP[1]:  reg_rdata <= {8'h00, setup[1]};
        ADDR_CONFIG:    reg_rdata <= {11'h000, ch_en[0], ch_en[1], op_mode};
        ADDR_TRIM_POS:  reg_rdata <= {8'h00, pos_trim_connect, 2'b00, pos_trim_code};
        ADDR_TRIM_NEG:  reg_rdata <= {8'h00, neg_trim_connect, 2'b00, neg_trim_code};
        ADDR_OFFSET[0]: reg_rdata <= offset[0];
        ADDR_OFFSET[1]: reg_rdata <= offset[1];
        ADDR_GAIN[0]:   reg_rdata <= gain[0];
        ADDR_GAIN[1]:   reg_rdata <= gain[1];
        ADDR_CONFIG2:   reg_rdata <= {10'h000, filter_rate_sel_hi, filter_rate_sel_lo, 4'h0};
        default:        reg_rdata <= '0;
      endcase
    end
  end
endmodule // cdc_trim_ctrl
`default_nettype wire

// ### testbench/cdc_trim_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port-level checks of the trim controller
// ----------------------------------------
module cdc_trim_ctrl_properties
  import cdc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Factory word and front end
  input wire logic [15:0] otp_gain,
  input wire logic [15:0] afe_pos_code,
  input wire logic [15:0] afe_neg_code,
  input wire logic        excitation_enable,
  input wire logic        afe_channel,
  input wire logic [1:0]  afe_range,
  input wire logic        afe_power_down,
  input wire logic        cap_neg_input_connect,
  input wire logic        pos_trim_connect,
  input wire logic [4:0]  pos_trim_code,
  input wire logic        neg_trim_connect,
  input wire logic [4:0]  neg_trim_code,
  input wire logic        filter_rate_sel_hi,
  input wire logic        filter_rate_sel_lo
);
  logic [15:0] wd_q;
  logic [2:0]  ld_cnt;
  logic        ofs_touched;
  logic        gain_touched;

  // Last write data, age since reset, host-moved coefficients
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_q         <= 16'h0000;
      ld_cnt       <= 3'h0;
      ofs_touched  <= 1'b0;
      gain_touched <= 1'b0;
    end else begin
      wd_q <= reg_wdata;
      if (ld_cnt != 3'h7) begin
        ld_cnt <= ld_cnt + 3'h1;
      end
      if (reg_wr && (reg_addr == ADDR_OFFSET[0] || reg_addr == ADDR_CONFIG)) begin
        ofs_touched <= 1'b1;
      end
      if (reg_wr && (reg_addr == ADDR_GAIN[0] || reg_addr == ADDR_CONFIG)) begin
        gain_touched <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Bus steps the checks start from
  sequence s_no_read;  !reg_rd ##1 1'b1; endsequence
  sequence s_pos_wr;   reg_wr && reg_addr == ADDR_TRIM_POS; endsequence
  sequence s_neg_wr;   reg_wr && reg_addr == ADDR_TRIM_NEG; endsequence
  sequence s_pdown_wr; reg_wr && reg_addr == ADDR_CONFIG && reg_wdata[2:0] == MODE_PDOWN; endsequence

  AST_RDATA_IDLE: assert property (s_no_read |-> reg_rdata == 16'h0000)
    else $error("read data not zero");
  AST_TRIM_POS: assert property (s_pos_wr |=> {pos_trim_connect, pos_trim_code} == {wd_q[7], wd_q[4:0]})
    else $error("positive trim mismatch");
  AST_TRIM_NEG: assert property (s_neg_wr |=> {neg_trim_connect, neg_trim_code} == {wd_q[7], wd_q[4:0]})
    else $error("negative trim mismatch");
  AST_RATE: assert property (reg_wr && reg_addr == ADDR_CONFIG2 |=> {filter_rate_sel_hi, filter_rate_sel_lo} == wd_q[5:4])
    else $error("filter setting mismatch");
  AST_OFFSET_RESET: assert property (reg_rd && reg_addr == ADDR_OFFSET[0] && !ofs_touched |=> reg_rdata == OFFSET_RESET)
    else $error("offset not at reset value");
  AST_GAIN_LOAD: assert property (reg_rd && reg_addr == ADDR_GAIN[0] && !gain_touched && ld_cnt == 3'h7 |=> reg_rdata == otp_gain)
    else $error("gain not the factory word");
  AST_LOAD_QUIET: assert property ($rose(rst_b) |-> (!excitation_enable) [*4])
    else $error("excitation during load");
  AST_NEG_CONNECT: assert property ($rose(cap_neg_input_connect) |-> ##[0:2] excitation_enable)
    else $error("negative input connected while idle");
  AST_PDOWN: assert property (s_pdown_wr |-> ##[1:3] afe_power_down)
    else $error("power-down not shown");
  AST_PDOWN_EXC: assert property (afe_power_down && $past(afe_power_down) |-> !excitation_enable)
    else $error("excitation while powered down");
endmodule // cdc_trim_ctrl_properties

bind cdc_trim_ctrl cdc_trim_ctrl_properties i_cdc_trim_ctrl_properties (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_gain(otp_gain), .afe_pos_code(afe_pos_code),
  .afe_neg_code(afe_neg_code), .excitation_enable(excitation_enable), .afe_channel(afe_channel),
  .afe_range(afe_range), .afe_power_down(afe_power_down),
  .cap_neg_input_connect(cap_neg_input_connect), .pos_trim_connect(pos_trim_connect),
  .pos_trim_code(pos_trim_code), .neg_trim_connect(neg_trim_connect),
  .neg_trim_code(neg_trim_code), .filter_rate_sel_hi(filter_rate_sel_hi),
  .filter_rate_sel_lo(filter_rate_sel_lo)
);
`default_nettype wire

// ### testbench/cdc_afe_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------
// Sensor front end and factory coefficient store
// ----------------------------------------------
module cdc_afe_model #(
  parameter logic [15:0] FACTORY_GAIN = 16'h4000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Controls from the converter
  input  wire logic        excitation_enable,
  input  wire logic        cap_neg_input_connect,
  // Capacitance levels chosen by the bench
  input  wire logic [15:0] pos_level,
  input  wire logic [15:0] neg_level,
  // Codes and factory word to the converter
  output logic      [15:0] afe_pos_code,
  output logic      [15:0] afe_neg_code,
  output logic      [15:0] otp_gain
);
  logic flip;

  // Unexcited inputs toggle so a stale sample cannot pass as data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flip <= 1'b0;
    end else begin
      flip <= ~flip;
    end
  end

  // Factory word is a fixed level from power-up on
  assign otp_gain = FACTORY_GAIN;
  // Positive input carries charge only while excited
  assign afe_pos_code = excitation_enable ? pos_level : ~pos_level ^ {16{flip}};
  // Negative input is seen only when a differential conversion connects it
  assign afe_neg_code = (excitation_enable && cap_neg_input_connect) ? neg_level
                      : ~neg_level ^ {16{flip}};
endmodule // cdc_afe_model
`default_nettype wire

// ### testbench/cdc_trim_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
module cdc_trim_ctrl_test;
  import cdc_pkg::*;
  localparam int NC [4] = '{20, 40, 60, 80};
  logic        clk, rst_b, reg_wr, reg_rd, excitation_enable, afe_channel, afe_power_down;
  logic        cap_neg_input_connect, pos_trim_connect, neg_trim_connect;
  logic        filter_rate_sel_hi, filter_rate_sel_lo;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, otp_gain, afe_pos_code, afe_neg_code;
  logic [15:0] pos_level, neg_level, rd_val;
  logic [1:0]  afe_range, rng, seen;
  logic [4:0]  pos_trim_code, neg_trim_code;
  int          err_total, comparisons, cnt;

  cdc_trim_ctrl #(.CONV_CYC_T0(20), .CONV_CYC_T1(40), .CONV_CYC_T2(60), .CONV_CYC_T3(80))
  i_cdc_trim_ctrl (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_gain(otp_gain),
    .afe_pos_code(afe_pos_code), .afe_neg_code(afe_neg_code),
    .excitation_enable(excitation_enable), .afe_channel(afe_channel), .afe_range(afe_range),
    .afe_power_down(afe_power_down), .cap_neg_input_connect(cap_neg_input_connect),
    .pos_trim_connect(pos_trim_connect), .pos_trim_code(pos_trim_code),
    .neg_trim_connect(neg_trim_connect), .neg_trim_code(neg_trim_code),
    .filter_rate_sel_hi(filter_rate_sel_hi), .filter_rate_sel_lo(filter_rate_sel_lo));
  cdc_afe_model i_cdc_afe_model (.clk(clk), .rst_b(rst_b), .excitation_enable(excitation_enable),
    .cap_neg_input_connect(cap_neg_input_connect), .pos_level(pos_level),
    .neg_level(neg_level), .afe_pos_code(afe_pos_code), .afe_neg_code(afe_neg_code),
    .otp_gain(otp_gain));

  // 250 MHz clock
  always #2 clk = ~clk;

  // One-cycle strobes; read data taken in the answer cycle
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    check(rd_val, exp);
  endtask
  // Start a mode and poll busy; a stuck converter counts as a mismatch
  task automatic run(input logic [15:0] cfg);
    wr(ADDR_CONFIG, cfg);
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      reg_addr <= ADDR_STATUS;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
      if (rd_val[ST_BUSY_BIT] === 1'b0) break;
    end
    check(16'(rd_val[ST_BUSY_BIT]), 16'h0000);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog: tests need under 2000 cycles
  initial begin
    #100000;
    err_total++;
    close_out();
  end

  // Main sequence
  initial begin
    {clk, rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    pos_level   = 16'h1000;
    neg_level   = 16'h0400;
    err_total   = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    rd_chk(ADDR_OFFSET[0], 16'h8000);
    rd_chk(ADDR_OFFSET[1], 16'h8000);
    rd_chk(ADDR_GAIN[0], 16'h4000);
    rd_chk(ADDR_GAIN[1], 16'h4000);
    rd_chk(8'h30, 16'h0000);
    wr(ADDR_TRIM_POS, 16'h00ff);
    rd_chk(ADDR_TRIM_POS, 16'h009f);
    check({10'h0, pos_trim_connect, pos_trim_code}, 16'h003f);
    wr(ADDR_TRIM_POS, 16'h0085);
    wr(ADDR_TRIM_NEG, 16'h0083);
    #1 check({10'h0, neg_trim_connect, neg_trim_code}, 16'h0023);
    wr(ADDR_GAIN[0], 16'h8000);
    rd_chk(ADDR_GAIN[0], 16'h8000);
    wr(ADDR_SETUP[0], 16'h0020);
    run(16'h0012);
    rd_chk(ADDR_RESULT[0], 16'h8b80);
    rd_chk(ADDR_CONFIG, 16'h0010);
    wr(ADDR_SETUP[0], 16'h0000);
    wr(ADDR_OFFSET[0], 16'h3000);
    run(16'h0012);
    rd_chk(ADDR_RESULT[0], 16'h0e00);
    wr(ADDR_TRIM_POS, 16'h009f);
    wr(ADDR_TRIM_NEG, 16'h0000);
    run(16'h0012);
    rd_chk(ADDR_RESULT[0], 16'h0840);
    // Calibrations on an offset well inside 40 percent of span
    wr(ADDR_TRIM_POS, 16'h0085);
    wr(ADDR_TRIM_NEG, 16'h0083);
    wr(ADDR_SETUP[0], 16'h0020);
    run(16'h0015);
    rd_chk(ADDR_OFFSET[0], 16'h7480);
    rd_chk(ADDR_CONFIG, 16'h0010);
    pos_level = 16'h9000;
    run(16'h0016);
    rd_chk(ADDR_GAIN[0], 16'hdc37);
    pos_level = 16'h1000;
    // Filter sets conversion length; range follows setup
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_CONFIG2, 16'(r) << 4);
      wr(ADDR_SETUP[0], (16'(r) << 6) | 16'h0020);
      wr(ADDR_CONFIG, 16'h0012);
      cnt = 0;
      repeat (120) begin
        @(posedge clk);
        #1;
        if (excitation_enable === 1'b1) begin
          cnt++;
          rng = afe_range;
        end
      end
      check(16'(cnt), 16'(NC[r]));
      check({14'h0, rng}, 16'(r));
    end
    // Continuous mode visits both channels
    wr(ADDR_CONFIG2, 16'h0000);
    wr(ADDR_CONFIG, 16'h0019);
    seen = 2'b00;
    repeat (150) begin
      @(posedge clk);
      #1;
      if (excitation_enable === 1'b1 && afe_channel === 1'b1) seen[1] = 1'b1;
      if (excitation_enable === 1'b1 && afe_channel === 1'b0) seen[0] = 1'b1;
    end
    check({14'h0, seen}, 16'h0003);
    wr(ADDR_CONFIG, 16'h0013);
    @(posedge clk);
    #1;
    check({15'h0, afe_power_down}, 16'h0001);
    wr(ADDR_CONFIG, 16'h0014);
    wr(ADDR_CONFIG, 16'h0017);
    rd_chk(ADDR_CONFIG, 16'h0013);
    wr(ADDR_CONFIG, 16'h0010);
    // Reset reloads gain; host restores its saved offset
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    rd_chk(ADDR_GAIN[0], 16'h4000);
    rd_chk(ADDR_OFFSET[0], 16'h8000);
    wr(ADDR_OFFSET[0], 16'h7480);
    rd_chk(ADDR_OFFSET[0], 16'h7480);
    close_out();
  end
endmodule // cdc_trim_ctrl_test
`default_nettype wire
